// ### verilog/tos_map.svh
// Constants of the timestamped output scheduler: offsets, fields, codes
`ifndef TOS_MAP_SVH
`define TOS_MAP_SVH

// =====================================================================
// Entry layout within the output image (byte offsets)
`define TOS_ENT_BYTES     4
`define TOS_ENT_CTRL      0
`define TOS_ENT_SEQ       1
`define TOS_ENT_TIME_LO   2
`define TOS_ENT_TIME_HI   3
`define TOS_TIME_W        16

// =====================================================================
// Output control byte fields
`define TOS_CTRL_LSB      4
`define TOS_CTRL_EN1      4
`define TOS_CTRL_EN0      5
`define TOS_CTRL_ST1      6
`define TOS_CTRL_ST0      7

// =====================================================================
// Sequence number fields
`define TOS_SEQ_MSB       5
`define TOS_SEQ_LAST      6
`define TOS_SEQ_FIRST     6'h01

// =====================================================================
// Status byte fixed bits and queue state codes
`define TOS_LAST_FIX      2'h1
`define TOS_NEXT_FIX      2'h3
`define TOS_CODE_OK       8'h00
`define TOS_CODE_NOSEQ    8'h01
`define TOS_CODE_EMPTY    8'h02
`define TOS_CODE_FULL     8'h03
`define TOS_CODE_MARK     8'h80

// =====================================================================
// Timing: microsecond ticker period in ns
`define TOS_US_NS         1000

`endif

// ### verilog/tos_pkg.sv
// Types shared by the timestamped output scheduler
package tos_pkg;

  // =====================================================================
  // Block scan state
  typedef enum logic {TOS_IDLE, TOS_SCAN} tos_scan_t;

  // =====================================================================
  // Outcome of the most recent entry check
  typedef enum logic [1:0] {TOS_EV_OK, TOS_EV_NOSEQ, TOS_EV_FULL} tos_event_t;

endpackage

// ### verilog/tos_fifo.sv
// Entry queue of the timestamped output scheduler, flip-flop storage
`timescale 1ns/1ps
module tos_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 31,
  parameter int CW    = $clog2(DEPTH + 1),
  parameter int PW    = $clog2(DEPTH)
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] headData,
  output logic      [CW-1:0]    count,
  output logic                  full,
  output logic                  empty
);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0]    rdPtr;
  logic [PW-1:0]    wrPtr;
  wire              doPush = push && !full;
  wire              doPop  = pop && !empty;
  wire  [PW-1:0]    lastPtr = PW'(DEPTH - 1);

  // Status decode
  assign full     = (count == CW'(DEPTH));
  assign empty    = (count == '0);
  assign headData = store[rdPtr];

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdPtr <= '0;
      wrPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == lastPtr) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == lastPtr) ? '0 : rdPtr + 1'b1;
      end
      count <= count + CW'(doPush) - CW'(doPop);
    end
  end

  // Storage needs no reset; only slots holding queued entries are ever used
  always_ff @(posedge clock) begin
    if (doPush) begin
      store[wrPtr] <= pushData;
    end
  end

endmodule // tos_fifo

// ### verilog/tos_scheduler.sv
// Two-channel timestamped output scheduler with checked entry queue
`timescale 1ns/1ps
`include "tos_map.svh"

// What this block does
// - Two output channels, own enable and state
// - Entry area holds 5 or 15 entries
// - Queue stores up to 31 entries
// - Entry: control, sequence, 16-bit time bytes
// - Full queue refuses and drops new entries
// - Status 0: last accepted sequence, 01 fixed
// - Status 1: next sequence to run, 11 fixed
// - Code 00h after successful store
// - Code 01h on sequence mismatch
// - Code 02h when queue holds nothing and no check has failed since the last store
// - Code 03h when queue is full
// - Code ORed 80h while marked entry queued
// - Entries after a marked entry are ignored
// - Status 3 holds current queue entry count
// - Control bits 4,5 enable channels 1,0
// - Control bits 6,7 give states 1,0
// - Fault lamp on overload, short or overheat
// - Free-running 32-bit microsecond ticker, wraps
// - Entry time sets when outputs apply
module tos_scheduler
  import tos_pkg::*;
#(
  parameter int SMALL_ENTRIES = 5,
  parameter int LARGE_ENTRIES = 15,
  parameter int QUEUE_DEPTH   = 31,
  parameter int CLK_NS        = 10
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        areaLarge,
  input  wire logic        imgWrite,
  input  wire logic [5:0]  imgAddr,
  input  wire logic [7:0]  imgData,
  input  wire logic        imgCommit,
  input  wire logic [1:0]  overloadIn,
  input  wire logic [1:0]  shortIn,
  input  wire logic [1:0]  hotIn,
  output logic      [1:0]  chOut,
  output logic      [1:0]  chEnable,
  output logic             faultLed,
  output logic      [7:0]  lastAcceptedSequence,
  output logic      [7:0]  nextSequenceToRun,
  output logic      [7:0]  queueStateCode,
  output logic      [7:0]  queueEntryCount,
  output logic      [31:0] usTicker
);

  // =====================================================================
  // Local constants
  localparam int IMG_BYTES  = LARGE_ENTRIES * `TOS_ENT_BYTES;
  localparam int US_CYCLES  = (`TOS_US_NS + CLK_NS - 1) / CLK_NS;
  localparam int PW         = $clog2(US_CYCLES);
  localparam int CW         = $clog2(QUEUE_DEPTH + 1);
  localparam int SW         = $clog2(LARGE_ENTRIES);
  // Queue word, top down: control nibble, marked sequence, time
  localparam int TW         = `TOS_TIME_W;
  localparam int SQW        = `TOS_SEQ_LAST + 1;
  localparam int CTW        = `TOS_CTRL_ST0 - `TOS_CTRL_LSB + 1;
  localparam int QW         = CTW + SQW + TW;
  localparam int SEQ_LSB    = TW;
  localparam int CTL_LSB    = TW + SQW;
  localparam logic [5:0] SMALL_BYTES =
    6'(SMALL_ENTRIES * `TOS_ENT_BYTES);
  localparam logic [5:0] LARGE_BYTES = 6'(IMG_BYTES);

  // =====================================================================
  // Output image written by the bus controller
  logic [7:0] image [0:IMG_BYTES-1];
  wire  [5:0] areaBytes = areaLarge ? LARGE_BYTES : SMALL_BYTES;
  wire        imgTake   = imgWrite && (imgAddr < areaBytes);

  // Out-of-area byte writes are dropped
  // Image persists across scans; only changed bytes need rewriting
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < IMG_BYTES; i++) begin
        image[i] <= 8'h00;
      end
    end else if (imgTake) begin
      image[imgAddr] <= imgData;
    end
  end

  // =====================================================================
  // Fault inputs come from pins: two-flop synchronisers
  // Any one of the six bits lights the lamp; no channel is named
  logic [5:0] faultMeta;
  logic [5:0] faultSync;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      faultMeta <= 6'h00;
      faultSync <= 6'h00;
    end else begin
      faultMeta <= {hotIn, shortIn, overloadIn};
      faultSync <= faultMeta;
    end
  end

  // =====================================================================
  // Microsecond ticker
  // Prescale rounds up: a clock that does not divide 1 us runs slow
  logic [PW-1:0] prescale;
  wire           usTick = (prescale == PW'(US_CYCLES - 1));

  // Free-running from reset, wraps to zero after all ones
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prescale <= '0;
      usTicker <= 32'h0000_0000;
    end else begin
      prescale <= usTick ? '0 : prescale + 1'b1;
      if (usTick) begin
        usTicker <= usTicker + 32'h0000_0001;
      end
    end
  end

  // =====================================================================
  // Entry queue
  logic          qPush;
  logic [QW-1:0] qPushData;
  logic          qPop;
  logic [QW-1:0] qHead;
  logic [CW-1:0] qCount;
  logic          qFull;
  logic          qEmpty;

  tos_fifo #(
    .WIDTH (QW),
    .DEPTH (QUEUE_DEPTH)
  ) tos_fifo_inst (
    .clock    (clock),
    .nrst     (nrst),
    .push     (qPush),
    .pushData (qPushData),
    .pop      (qPop),
    .headData (qHead),
    .count    (qCount),
    .full     (qFull),
    .empty    (qEmpty)
  );

  // =====================================================================
  // Block scan: one entry slot checked per clock after a commit
  // A commit during a scan is ignored; the host waits the scan out
  tos_scan_t  scanState;
  tos_event_t lastEvent;
  logic [SW-1:0] slot;
  logic [SW-1:0] slotLast;
  logic [5:0]    expectSeq;
  logic [5:0]    lastSeq;

  wire  [5:0] base     = 6'(slot) * 6'(`TOS_ENT_BYTES);
  wire  [7:0] entCtrl  = image[base + 6'(`TOS_ENT_CTRL)];
  wire  [7:0] entSeq   = image[base + 6'(`TOS_ENT_SEQ)];
  wire  [15:0] entTime = {image[base + 6'(`TOS_ENT_TIME_HI)],
                          image[base + 6'(`TOS_ENT_TIME_LO)]};
  wire        scanning = (scanState == TOS_SCAN);
  wire        seqMatch = (entSeq[`TOS_SEQ_MSB:0] == expectSeq);
  wire        entMark  = entSeq[`TOS_SEQ_LAST];
  wire        refuse   = scanning && qFull;
  wire        badSeq   = scanning && !qFull && !seqMatch;

  // Only a matching entry with room is stored
  assign qPush     = scanning && !qFull && seqMatch;
  assign qPushData = {entCtrl[`TOS_CTRL_ST0:`TOS_CTRL_EN1],
                      entSeq[`TOS_SEQ_LAST:0], entTime};
  wire   scanStop  = refuse || badSeq || entMark
                     || (slot == slotLast);

  // Scan ends at a mark, a refusal, a mismatch or the area's end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      scanState <= TOS_IDLE;
      slot      <= '0;
      slotLast  <= '0;
    end else begin
      unique case (scanState)
        TOS_IDLE: begin
          if (imgCommit) begin
            scanState <= TOS_SCAN;
            slot      <= '0;
            slotLast  <= areaLarge ? SW'(LARGE_ENTRIES - 1)
                                   : SW'(SMALL_ENTRIES - 1);
          end
        end
        TOS_SCAN: begin
          if (scanStop) begin
            scanState <= TOS_IDLE;
          end else begin
            slot <= slot + 1'b1;
          end
        end
      endcase
    end
  end

  // Expected and last accepted sequence advance only on a store
  // Sequence wraps modulo 64, as the host's numbering does
  always_ff @(posedge clock) begin
    if (!nrst) begin
      expectSeq <= `TOS_SEQ_FIRST;
      lastSeq   <= 6'h00;
      lastEvent <= TOS_EV_OK;
    end else begin
      if (qPush) begin
        expectSeq <= expectSeq + 6'h01;
        lastSeq   <= entSeq[`TOS_SEQ_MSB:0];
        lastEvent <= TOS_EV_OK;
      end else if (badSeq) begin
        lastEvent <= TOS_EV_NOSEQ;
      end else if (refuse) begin
        lastEvent <= TOS_EV_FULL;
      end
    end
  end

  // =====================================================================
  // Execution of the head entry
  wire [CTW-1:0] headCtrl = qHead[QW-1:CTL_LSB];
  wire [SQW-1:0] headSeq  = qHead[CTL_LSB-1:SEQ_LSB];
  wire [TW-1:0]  headTime = qHead[TW-1:0];
  // A passed time waits for the next wrap of the low ticker half.
  // The ticker holds each value for many clocks, so entries sharing
  // one time run back to back, one per clock.
  assign qPop = !qEmpty && (usTicker[15:0] == headTime);

  // Control nibble holds bits 7..4 of the original byte
  wire en1 = headCtrl[`TOS_CTRL_EN1 - `TOS_CTRL_LSB];
  wire en0 = headCtrl[`TOS_CTRL_EN0 - `TOS_CTRL_LSB];
  wire st1 = headCtrl[`TOS_CTRL_ST1 - `TOS_CTRL_LSB];
  wire st0 = headCtrl[`TOS_CTRL_ST0 - `TOS_CTRL_LSB];

  // Outputs update at the executing edge, in arrival order
  always_ff @(posedge clock) begin
    if (!nrst) begin
      chEnable <= 2'h0;
      chOut    <= 2'h0;
    end else if (qPop) begin
      chEnable <= {en1, en0};
      chOut    <= {en1 & st1, en0 & st0};
    end
  end

  // =====================================================================
  // Count of queued entries carrying the last-entry mark
  // A count, not a flag: several marked blocks may wait at once
  logic [CW-1:0] markCount;
  wire           markIn  = qPush && entMark;
  wire           markOut = qPop && headSeq[`TOS_SEQ_LAST];

  always_ff @(posedge clock) begin
    if (!nrst) begin
      markCount <= '0;
    end else begin
      markCount <= markCount + CW'(markIn) - CW'(markOut);
    end
  end

  // =====================================================================
  // Status bytes, decoded then registered
  // Full outranks all; a mismatch code stays until the next good store or refusal,
  // so a host that polls late still sees why its block was dropped.
  wire [7:0] baseCode =
    qFull                      ? `TOS_CODE_FULL  :
    (lastEvent == TOS_EV_NOSEQ) ? `TOS_CODE_NOSEQ :
    (lastEvent == TOS_EV_FULL)  ? `TOS_CODE_FULL  :
    qEmpty                     ? `TOS_CODE_EMPTY :
                                 `TOS_CODE_OK;
  wire [7:0] next_code = baseCode |
    ((markCount != '0) ? `TOS_CODE_MARK : 8'h00);
  wire [5:0] runSeq    = qEmpty ? expectSeq : headSeq[`TOS_SEQ_MSB:0];
  wire       anyFault  = |faultSync;

  // Status and lamp all come from flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lastAcceptedSequence <= {`TOS_LAST_FIX, 6'h00};
      nextSequenceToRun    <= {`TOS_NEXT_FIX, `TOS_SEQ_FIRST};
      queueStateCode       <= `TOS_CODE_EMPTY;
      queueEntryCount      <= 8'h00;
      faultLed             <= 1'b0;
    end else begin
      lastAcceptedSequence <= {`TOS_LAST_FIX, lastSeq};
      nextSequenceToRun    <= {`TOS_NEXT_FIX, runSeq};
      queueStateCode       <= next_code;
      queueEntryCount      <= 8'(qCount);
      faultLed             <= anyFault;
    end
  end

endmodule // tos_scheduler

// ### tb/tos_host_model.sv
// Bus controller model that fills the output image and commits it
`timescale 1ns/1ps
module tos_host_model (
  input  wire logic       clock,
  output logic            imgWrite,
  output logic      [5:0] imgAddr,
  output logic      [7:0] imgData,
  output logic            imgCommit
);
  // =====================================================================
  // Idle levels at time zero
  initial begin
    imgWrite = 1'b0;
    imgAddr = 6'h00;
    imgData = 8'h00;
    imgCommit = 1'b0;
  end

  // One byte per edge, changed just after the edge
  task automatic put_byte(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    imgWrite = 1'b1;
    imgAddr = a;
    imgData = d;
  endtask

  // Whole entry, time low byte first
  task automatic put_entry(input logic [3:0] slot, input logic [7:0] ctl,
                           input logic [7:0] sq, input logic [15:0] t);
    put_byte({slot, 2'h0}, ctl);
    put_byte({slot, 2'h1}, sq);
    put_byte({slot, 2'h2}, t[7:0]);
    put_byte({slot, 2'h3}, t[15:8]);
  endtask

  // Commit, then stay silent while the scan runs
  task automatic commit();
    @(posedge clock);
    #1;
    imgWrite = 1'b0;
    imgAddr = ~imgAddr;
    imgData = ~imgData; // Released bus must not look valid
    imgCommit = 1'b1;
    @(posedge clock);
    #1;
    imgCommit = 1'b0;
    repeat (17) @(posedge clock);
    #1;
  endtask
endmodule // tos_host_model

// ### tb/tos_scheduler_chk.sv
// Port checker of the timestamped output scheduler
`timescale 1ns/1ps
module tos_scheduler_chk #(
  parameter int QUEUE_DEPTH = 31
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [1:0]  overloadIn,
  input wire logic [1:0]  shortIn,
  input wire logic [1:0]  hotIn,
  input wire logic [1:0]  chOut,
  input wire logic [1:0]  chEnable,
  input wire logic        faultLed,
  input wire logic [7:0]  lastAcceptedSequence,
  input wire logic [7:0]  nextSequenceToRun,
  input wire logic [7:0]  queueStateCode,
  input wire logic [7:0]  queueEntryCount,
  input wire logic [31:0] usTicker
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // =====================================================================
  // Cycles since the ticker last moved; catches a stalled prescaler
  logic [7:0]  gap;
  logic [31:0] prevTick;
  wire         anyFault = |(overloadIn | shortIn | hotIn);
  always_ff @(posedge clock) begin
    prevTick <= usTicker;
    gap <= (!nrst || usTicker != prevTick) ? 8'h00 : gap + 8'h01;
  end

  property p_last_fix; lastAcceptedSequence[7:6] == 2'h1; endproperty
  a_last_fix: assert property (p_last_fix)
    else $error("last accepted fixed bits wrong");
  property p_next_fix; nextSequenceToRun[7:6] == 2'h3; endproperty
  a_next_fix: assert property (p_next_fix)
    else $error("next sequence fixed bits wrong");
  property p_count_max; queueEntryCount <= 8'(QUEUE_DEPTH); endproperty
  a_count_max: assert property (p_count_max)
    else $error("queue count above depth");
  property p_full_code;
    queueEntryCount == 8'(QUEUE_DEPTH) |-> queueStateCode[1:0] == 2'h3;
  endproperty
  a_full_code: assert property (p_full_code)
    else $error("full queue without full code");
  property p_empty_code;
    queueEntryCount == 8'h00 |-> queueStateCode inside {8'h01, 8'h02, 8'h03};
  endproperty
  a_empty_code: assert property (p_empty_code)
    else $error("empty queue with wrong code");
  property p_disabled_off; (chOut & ~chEnable) == 2'h0; endproperty
  a_disabled_off: assert property (p_disabled_off)
    else $error("disabled channel driven");
  property p_count_step;
    $changed(queueEntryCount) |-> queueEntryCount == $past(queueEntryCount)
      + 8'h01 || queueEntryCount == $past(queueEntryCount) - 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("queue count jumped");
  property p_tick_step;
    $changed(usTicker) |-> usTicker == $past(usTicker) + 32'h00000001;
  endproperty
  a_tick_step: assert property (p_tick_step)
    else $error("ticker stepped wrongly");
  property p_tick_rate; gap < 8'h66; endproperty
  a_tick_rate: assert property (p_tick_rate)
    else $error("ticker stalled");
  property p_exec_src;
    $changed(chEnable) || $changed(chOut) |-> queueEntryCount != 8'h00;
  endproperty
  a_exec_src: assert property (p_exec_src)
    else $error("outputs changed without queued entry");
  property p_fault_on; anyFault [*4] |=> faultLed; endproperty
  a_fault_on: assert property (p_fault_on)
    else $error("fault lamp missing");
  property p_fault_off; !anyFault [*4] |=> !faultLed; endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault lamp stuck");

  // Main scenarios reached
  c_full: cover property (queueStateCode == 8'h03);
  c_mark: cover property (queueStateCode == 8'h80);
  c_exec: cover property ($changed(chEnable));
endmodule // tos_scheduler_chk

bind tos_scheduler tos_scheduler_chk #(.QUEUE_DEPTH(QUEUE_DEPTH))
  tos_scheduler_chk_inst (.clock(clock), .nrst(nrst),
  .overloadIn(overloadIn), .shortIn(shortIn), .hotIn(hotIn),
  .chOut(chOut), .chEnable(chEnable), .faultLed(faultLed),
  .lastAcceptedSequence(lastAcceptedSequence),
  .nextSequenceToRun(nextSequenceToRun), .queueStateCode(queueStateCode),
  .queueEntryCount(queueEntryCount), .usTicker(usTicker));

// ### tb/tos_scheduler_bench.sv
// Self-checking bench of the timestamped output scheduler
`timescale 1ns/1ps
module tos_scheduler_bench;
  logic        clock, nrst, areaLarge, imgWrite, imgCommit, faultLed;
  logic [5:0]  imgAddr;
  logic [7:0]  imgData, lastSeq, nextSeq, stateCode, entryCount;
  logic [1:0]  overloadIn, shortIn, hotIn, chOut, chEnable;
  logic [31:0] usTicker;
  int          fails, compares, b, s;

  tos_host_model tos_host_model_inst (.clock(clock), .imgWrite(imgWrite),
    .imgAddr(imgAddr), .imgData(imgData), .imgCommit(imgCommit));
  tos_scheduler tos_scheduler_inst (.clock(clock), .nrst(nrst),
    .areaLarge(areaLarge), .imgWrite(imgWrite), .imgAddr(imgAddr),
    .imgData(imgData), .imgCommit(imgCommit), .overloadIn(overloadIn),
    .shortIn(shortIn), .hotIn(hotIn), .chOut(chOut), .chEnable(chEnable),
    .faultLed(faultLed), .lastAcceptedSequence(lastSeq),
    .nextSequenceToRun(nextSeq), .queueStateCode(stateCode),
    .queueEntryCount(entryCount), .usTicker(usTicker));

  // =====================================================================
  // Clock, 10 ns period
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // All four status bytes at once
  task automatic st(input logic [7:0] l, n, c, k);
    chk("lastAcceptedSequence", l, lastSeq);
    chk("nextSequenceToRun", n, nextSeq);
    chk("queueStateCode", c, stateCode);
    chk("queueEntryCount", k, entryCount);
  endtask

  // Bounded wait; a hang counts as a mismatch and ends the run
  task automatic wait_until(input bit idle, input logic lvl);
    int i;
    for (i = 0; i < 2000; i++) begin
      if (idle ? entryCount === 8'h00 : faultLed === lvl) break;
      @(posedge clock);
      #1;
    end
    if (i == 2000) begin
      fails++;
      $display("Error wait expected done seen timeout");
      end_sim;
    end
    @(posedge clock);
    #1;
  endtask

  // One marked entry that runs 3 us from now
  task automatic run(input logic [7:0] ctl, sq, input logic [1:0] en, o);
    logic [15:0] t;
    t = usTicker[15:0] + 16'h0003;
    tos_host_model_inst.put_entry(4'h0, ctl, sq, t);
    tos_host_model_inst.commit();
    st(8'h40 | sq & 8'h3F, 8'hC0 | sq, 8'h80, 8'h01);
    wait_until(1'b1, 1'b0);
    chk("usTicker", t[7:0], usTicker[7:0]);
    chk("chEnable", {6'h00, en}, {6'h00, chEnable});
    chk("chOut", {6'h00, o}, {6'h00, chOut});
    chk("queueStateCode", 8'h02, stateCode);
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    fails = 0;
    compares = 0;
    nrst = 1'b0;
    areaLarge = 1'b0;
    {hotIn, shortIn, overloadIn} = 6'h00;
    for (b = 0; b < 2; b++) begin
      repeat (12) @(posedge clock);
      #1;
      nrst = 1'b1;
      @(posedge clock);
      #1;
      st(8'h40, 8'hC1, 8'h02, 8'h00);
      if (b == 1) break;
      chk("chEnable", 8'h00, {6'h00, chEnable});
      run(8'hF0, 8'h41, 2'h3, 2'h3);
      run(8'hD0, 8'h42, 2'h2, 2'h2);
      tos_host_model_inst.put_entry(4'h0, 8'hF0, 8'h45, 16'hF000);
      tos_host_model_inst.commit();
      st(8'h42, 8'hC3, 8'h01, 8'h00);
      areaLarge = 1'b1;
      for (s = 0; s < 45; s++) begin
        tos_host_model_inst.put_entry(4'(s % 15), 8'h00, 8'(3 + s), 16'hF000);
        if (s % 15 == 14) begin
          tos_host_model_inst.commit();
          st(8'h40 + 8'((s < 44) ? s + 3 : 33), 8'hC3,
             (s < 44) ? 8'h00 : 8'h03,
             8'((s < 44) ? s + 1 : 31));
        end
      end
      for (s = 0; s < 3; s++) begin
        {hotIn, shortIn, overloadIn} = 6'(1 << (2 * s + s % 2));
        wait_until(1'b0, 1'b1);
        chk("faultLed", 8'h01, {7'h00, faultLed});
        {hotIn, shortIn, overloadIn} = 6'h00;
        wait_until(1'b0, 1'b0);
        chk("faultLed", 8'h00, {7'h00, faultLed});
      end
      nrst = 1'b0;
      areaLarge = 1'b0;
    end
    tos_host_model_inst.put_entry(4'h0, 8'h00, 8'h01, 16'hF000);
    tos_host_model_inst.put_entry(4'h1, 8'h00, 8'h42, 16'hF000);
    tos_host_model_inst.put_entry(4'h2, 8'h00, 8'h03, 16'hF000);
    tos_host_model_inst.commit();
    st(8'h42, 8'hC1, 8'h80, 8'h02);
    end_sim;
  end
endmodule // tos_scheduler_bench
